// *** hdl/bdte_engine.sv ***
`timescale 1ns/100ps
// Operation
// - one byte per transaction, messages many
// - read source into buffer, then write
// - two bus cycles: read then write
// - pending flag set while buffer unwritten
// - pending clear after write or on abort
// - reads three spaces, writes data space
// - bus used only after arbiter grant
// - engine priority stalls processor until done
// - processor priority: engine uses bubbles only
// - shares existing buses, no dual ports
// - pointer modes fixed, increment, decrement
// - pointers, counters update and reload
// - auto-stop on source or destination counter
// - software go or selected hardware trigger
// - selected hardware abort source stops transfer
// - independent instances chosen by instance select
// - software avoids pointing at arbiter registers
// - go starts message, smaller counter ends
// - start copies sizes, both counters decrement
// - counter reaching zero clears go, reloads
// - mode fields step by one; space select
module bdte_engine (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [bdte_pkg::PAW-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // hardware request sources
    input  wire logic [bdte_pkg::NTRIG-1:0] hw_trig,
    // shared memory bus
    bdte_bus_if.engine                   bus
);
    import bdte_pkg::*;

    typedef enum logic [1:0] {E_IDLE, E_RD, E_WR} bdte_state_e;

    ////////////////////////////////////////////////////////////////////
    logic [AW-1:0]    ssa_q [NCH];
    logic [AW-1:0]    dsa_q [NCH];
    logic [AW-1:0]    sptr_q [NCH];
    logic [AW-1:0]    dptr_q [NCH];
    logic [CW-1:0]    ssz_q [NCH];
    logic [CW-1:0]    dsz_q [NCH];
    logic [CW-1:0]    scnt_q [NCH];
    logic [CW-1:0]    dcnt_q [NCH];
    logic [7:0]       ctlb_q [NCH];
    logic [TW-1:0]    sirq_q [NCH];
    logic [TW-1:0]    airq_q [NCH];
    logic [7:0]       buf_q [NCH];
    logic [NCH-1:0]   en_q, go_q, sten_q, aben_q, pend_q, abp_q;
    logic [NTRIG-1:0] trig_prev_q;
    logic [IW-1:0]    isel_q;
    logic [IW-1:0]    cur_q;
    bdte_state_e      state_q;
    logic             req_q, we_q;
    logic [1:0]       space_q;
    logic [AW-1:0]    addr_q;
    logic [7:0]       wdata_q;
    logic [31:0]      prdata_q;
    logic             pready_q, pslverr_q;

    ////////////////////////////////////////////////////////////////////
    // apb decode: answer one cycle into the access phase
    wire              acc     = psel && penable;
    wire              fire    = acc && pready_q;
    wire              wr_fire = fire && pwrite;
    wire              mapped  = (paddr <= OFF_BUF) && (paddr[1:0] == 2'b00);
    wire [PAW-1:0]    a       = paddr;
    wire [IW-1:0]     s       = isel_q;
    wire [NTRIG-1:0]  trig_rise = hw_trig & ~trig_prev_q;
    wire [31:0]       ctla_rd = {27'h0, pend_q[s], aben_q[s], sten_q[s], go_q[s], en_q[s]};
    wire [31:0]       rd_word =
        (a == OFF_SELECT) ? {30'h0, isel_q} :
        (a == OFF_CTLA)   ? ctla_rd :
        (a == OFF_CTLB)   ? {24'h0, ctlb_q[s]} :
        (a == OFF_SSA)    ? {16'h0, ssa_q[s]} :
        (a == OFF_DSA)    ? {16'h0, dsa_q[s]} :
        (a == OFF_SSZ)    ? {20'h0, ssz_q[s]} :
        (a == OFF_DSZ)    ? {20'h0, dsz_q[s]} :
        (a == OFF_SPTR)   ? {16'h0, sptr_q[s]} :
        (a == OFF_DPTR)   ? {16'h0, dptr_q[s]} :
        (a == OFF_SCNT)   ? {20'h0, scnt_q[s]} :
        (a == OFF_DCNT)   ? {20'h0, dcnt_q[s]} :
        (a == OFF_SIRQ)   ? {29'h0, sirq_q[s]} :
        (a == OFF_AIRQ)   ? {29'h0, airq_q[s]} :
        (a == OFF_BUF)    ? {24'h0, buf_q[s]} : 32'h0;

    // bus completion events
    wire              rd_done = (state_q == E_RD) && bus.grant;
    wire              wr_done = (state_q == E_WR) && bus.grant;

    // lowest ready instance wins; fixed order keeps it small
    logic [IW-1:0]    pick;
    logic             pick_ok;
    always_comb begin
        pick    = '0;
        pick_ok = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (en_q[i] && go_q[i] && !abp_q[i]) begin
                pick    = IW'(i);
                pick_ok = 1'b1;
            end
        end
    end

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p, input logic [1:0] m);
        case (m)
            MODE_INC: step = p + 16'h0001;
            MODE_DEC: step = p - 16'h0001;
            default:  step = p;
        endcase
    endfunction : step

    ////////////////////////////////////////////////////////////////////
    // per-instance registers and counters
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire       me      = (s == IW'(c));
        wire       wsel    = wr_fire && me;
        wire       busy    = (state_q != E_IDLE) && (cur_q == IW'(c));
        wire       rd_c    = rd_done && (cur_q == IW'(c));
        wire       wr_c    = wr_done && (cur_q == IW'(c)) && !abp_q[c];
        wire       s_wrap  = wr_c && (scnt_q[c] == 12'h001);
        wire       d_wrap  = wr_c && (dcnt_q[c] == 12'h001);
        wire       ab_hit  = aben_q[c] && trig_rise[airq_q[c]] && go_q[c];
        wire       ab_do   = abp_q[c] && !busy;
        wire       w_ctla  = wsel && (a == OFF_CTLA);
        wire       start   = w_ctla && pwdata[CA_EN] && !en_q[c];
        wire       go_set  = (w_ctla && pwdata[CA_GO])
                             || (sten_q[c] && en_q[c] && trig_rise[sirq_q[c]]);
        wire       go_clr  = s_wrap || d_wrap || ab_do || (w_ctla && !pwdata[CA_GO]);
        wire       st_clr  = (s_wrap && ctlb_q[c][CB_SSTP]) || (d_wrap && ctlb_q[c][CB_DSTP]);
        wire       rl_s    = start || s_wrap || ab_do;
        wire       rl_d    = start || d_wrap || ab_do;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ssa_q[c]  <= RST_ADDR;
                dsa_q[c]  <= RST_ADDR;
                sptr_q[c] <= RST_ADDR;
                dptr_q[c] <= RST_ADDR;
                ssz_q[c]  <= RST_SIZE;
                dsz_q[c]  <= RST_SIZE;
                scnt_q[c] <= RST_SIZE;
                dcnt_q[c] <= RST_SIZE;
                ctlb_q[c] <= 8'h00;
                sirq_q[c] <= '0;
                airq_q[c] <= '0;
                buf_q[c]  <= 8'h00;
                en_q[c]   <= 1'b0;
                go_q[c]   <= 1'b0;
                sten_q[c] <= 1'b0;
                aben_q[c] <= 1'b0;
                pend_q[c] <= 1'b0;
                abp_q[c]  <= 1'b0;
            end else begin
                if (wsel && a == OFF_SSA)  ssa_q[c]  <= pwdata[AW-1:0];
                if (wsel && a == OFF_DSA)  dsa_q[c]  <= pwdata[AW-1:0];
                if (wsel && a == OFF_SSZ)  ssz_q[c]  <= pwdata[CW-1:0];
                if (wsel && a == OFF_DSZ)  dsz_q[c]  <= pwdata[CW-1:0];
                if (wsel && a == OFF_CTLB) ctlb_q[c] <= pwdata[7:0];
                if (wsel && a == OFF_SIRQ) sirq_q[c] <= pwdata[TW-1:0];
                if (wsel && a == OFF_AIRQ) airq_q[c] <= pwdata[TW-1:0];
                if (w_ctla) begin
                    en_q[c]   <= pwdata[CA_EN];
                    aben_q[c] <= pwdata[CA_ABEN];
                end
                // set wins over clear
                go_q[c]   <= go_set || (go_q[c] && !go_clr);
                sten_q[c] <= (w_ctla && pwdata[CA_STEN]) || (sten_q[c] && !st_clr && !w_ctla);
                abp_q[c]  <= ab_hit || (abp_q[c] && !ab_do);
                if (rd_c) begin
                    buf_q[c] <= bus.rdata;
                end
                pend_q[c] <= rd_c || (pend_q[c] && !wr_done && !ab_do);
                if (rl_s) begin
                    scnt_q[c] <= ssz_q[c];
                    sptr_q[c] <= ssa_q[c];
                end else if (wr_c) begin
                    scnt_q[c] <= scnt_q[c] - 12'h001;
                    sptr_q[c] <= step(sptr_q[c], ctlb_q[c][CB_SOURCE_POINTER_MODE +: 2]);
                end
                if (rl_d) begin
                    dcnt_q[c] <= dsz_q[c];
                    dptr_q[c] <= dsa_q[c];
                end else if (wr_c) begin
                    dcnt_q[c] <= dcnt_q[c] - 12'h001;
                    dptr_q[c] <= step(dptr_q[c], ctlb_q[c][CB_DESTINATION_POINTER_MODE +: 2]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transaction sequencer: read cycle then write cycle, request held until grant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= E_IDLE;
            cur_q   <= '0;
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            space_q <= SPACE_DATA;
            addr_q  <= RST_ADDR;
            wdata_q <= 8'h00;
        end else begin
            case (state_q)
                E_IDLE: begin
                    if (pick_ok) begin
                        state_q <= E_RD;
                        cur_q   <= pick;
                        req_q   <= 1'b1;
                        we_q    <= 1'b0;
                        space_q <= ctlb_q[pick][CB_SPACE +: 2];
                        addr_q  <= sptr_q[pick];
                    end
                end
                E_RD: begin
                    if (rd_done) begin
                        if (abp_q[cur_q]) begin
                            // aborted: drop the byte, skip the write
                            state_q <= E_IDLE;
                            req_q   <= 1'b0;
                        end else begin
                            state_q <= E_WR;
                            we_q    <= 1'b1;
                            space_q <= SPACE_DATA;
                            addr_q  <= dptr_q[cur_q];
                            wdata_q <= bus.rdata;
                        end
                    end
                end
                E_WR: begin
                    if (wr_done) begin
                        state_q <= E_IDLE;
                        req_q   <= 1'b0;
                        we_q    <= 1'b0;
                    end
                end
                default: begin
                    state_q <= E_IDLE;
                    req_q   <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isel_q      <= '0;
            trig_prev_q <= '0;
            prdata_q    <= 32'h0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
        end else begin
            trig_prev_q <= hw_trig;
            pready_q    <= acc && !pready_q;
            if (acc && !pready_q) begin
                prdata_q  <= pwrite ? 32'h0 : (mapped ? rd_word : 32'h0);
                pslverr_q <= !mapped;
            end
            if (wr_fire && a == OFF_SELECT) begin
                isel_q <= pwdata[IW-1:0];
            end
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign bus.req   = req_q;
    assign bus.we    = we_q;
    assign bus.space = space_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
endmodule : bdte_engine

// *** hdl/bdte_pkg.sv ***
package bdte_pkg;
    // sizes
    localparam int NCH   = 4;
    localparam int IW    = 2;
    localparam int AW    = 16;
    localparam int CW    = 12;
    localparam int NTRIG = 8;
    localparam int TW    = 3;
    localparam int PAW   = 8;

    // apb word offsets
    localparam logic [PAW-1:0] OFF_SELECT = 8'h00;
    localparam logic [PAW-1:0] OFF_CTLA   = 8'h04;
    localparam logic [PAW-1:0] OFF_CTLB   = 8'h08;
    localparam logic [PAW-1:0] OFF_SSA    = 8'h0C;
    localparam logic [PAW-1:0] OFF_DSA    = 8'h10;
    localparam logic [PAW-1:0] OFF_SSZ    = 8'h14;
    localparam logic [PAW-1:0] OFF_DSZ    = 8'h18;
    localparam logic [PAW-1:0] OFF_SPTR   = 8'h1C;
    localparam logic [PAW-1:0] OFF_DPTR   = 8'h20;
    localparam logic [PAW-1:0] OFF_SCNT   = 8'h24;
    localparam logic [PAW-1:0] OFF_DCNT   = 8'h28;
    localparam logic [PAW-1:0] OFF_SIRQ   = 8'h2C;
    localparam logic [PAW-1:0] OFF_AIRQ   = 8'h30;
    localparam logic [PAW-1:0] OFF_BUF    = 8'h34;

    // engine_control_a bits
    localparam int CA_EN   = 0;
    localparam int CA_GO   = 1;
    localparam int CA_STEN = 2;
    localparam int CA_ABEN = 3;
    localparam int CA_PEND = 4;
    // engine_control_b fields
    localparam int CB_DESTINATION_POINTER_MODE = 0;
    localparam int CB_SOURCE_POINTER_MODE = 2;
    localparam int CB_SPACE = 4;
    localparam int CB_SSTP  = 6;
    localparam int CB_DSTP  = 7;

    // reset values
    localparam logic [AW-1:0] RST_ADDR = 16'h0000;
    localparam logic [CW-1:0] RST_SIZE = 12'h001;

    typedef enum logic [1:0] {MODE_FIXED, MODE_INC, MODE_DEC, MODE_FIXED2} bdte_mode_e;
    typedef enum logic [1:0] {SPACE_DATA, SPACE_FLASH, SPACE_EEPROM, SPACE_RSVD} bdte_space_e;
endpackage : bdte_pkg

// *** hdl/bdte_bus_if.sv ***
`timescale 1ns/100ps
interface bdte_bus_if;
    import bdte_pkg::*;
    logic                req;
    logic                we;
    logic [1:0]          space;
    logic [AW-1:0]       addr;
    logic [7:0]          wdata;
    logic                grant;
    logic [7:0]          rdata;

    modport engine  (output req, we, space, addr, wdata, input grant, rdata);
    modport arbiter (input req, we, space, addr, wdata, output grant, rdata);
endinterface : bdte_bus_if

// *** hdl/bdte_arbiter.sv ***
`timescale 1ns/100ps
module bdte_arbiter (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // engine side
    bdte_bus_if.arbiter                 bus,
    // processor side
    input  wire logic                   dma_priority,
    input  wire logic                   cpu_bubble_next,
    output logic                        cpu_stall,
    // memory port, read data combinational during mem_en
    output logic                        mem_en,
    output logic                        mem_we,
    output logic [1:0]                  mem_space,
    output logic [bdte_pkg::AW-1:0]     mem_addr,
    output logic [7:0]                  mem_wdata,
    input  wire logic [7:0]             mem_rdata
);
    import bdte_pkg::*;

    typedef enum logic [1:0] {A_IDLE, A_ACC, A_DONE} bdte_arb_e;

    bdte_arb_e        state_q;
    logic             grant_q, stall_q, en_q, we_q;
    logic [1:0]       space_q;
    logic [AW-1:0]    addr_q;
    logic [7:0]       wdata_q, rdata_q;

    // bubble use only when the processor leads
    wire              allow = dma_priority || cpu_bubble_next;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= A_IDLE;
            grant_q <= 1'b0;
            stall_q <= 1'b0;
            en_q    <= 1'b0;
            we_q    <= 1'b0;
            space_q <= SPACE_DATA;
            addr_q  <= '0;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            // stall follows, one cycle late, the engine holding a request while dma_priority is set
            stall_q <= dma_priority && bus.req;
            case (state_q)
                A_IDLE: begin
                    grant_q <= 1'b0;
                    if (bus.req && allow) begin
                        state_q <= A_ACC;
                        en_q    <= 1'b1;
                        we_q    <= bus.we;
                        space_q <= bus.space;
                        addr_q  <= bus.addr;
                        wdata_q <= bus.wdata;
                    end
                end
                A_ACC: begin
                    en_q    <= 1'b0;
                    we_q    <= 1'b0;
                    rdata_q <= mem_rdata;
                    grant_q <= 1'b1;
                    state_q <= A_DONE;
                end
                A_DONE: begin
                    // stale request in this cycle is ignored
                    grant_q <= 1'b0;
                    state_q <= A_IDLE;
                end
                default: begin
                    state_q <= A_IDLE;
                    grant_q <= 1'b0;
                    en_q    <= 1'b0;
                end
            endcase
        end
    end

    assign bus.grant = grant_q;
    assign bus.rdata = rdata_q;
    assign cpu_stall = stall_q;
    assign mem_en    = en_q;
    assign mem_we    = we_q;
    assign mem_space = space_q;
    assign mem_addr  = addr_q;
    assign mem_wdata = wdata_q;
endmodule : bdte_arbiter

// *** testbench/bdte_checker_props.sv ***
`timescale 1ns/100ps
module bdte_checker (
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // engine bus
    input wire logic                    req,
    input wire logic                    we,
    input wire logic [1:0]              space,
    input wire logic [bdte_pkg::AW-1:0] addr,
    input wire logic [7:0]              wdata,
    input wire logic                    grant,
    input wire logic [7:0]              rdata,
    // arbiter side
    input wire logic                    dma_priority,
    input wire logic                    cpu_bubble_next,
    input wire logic                    cpu_stall,
    input wire logic                    mem_en,
    input wire logic                    mem_we,
    input wire logic [bdte_pkg::AW-1:0] mem_addr,
    input wire logic [7:0]              mem_rdata
);
    import bdte_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_read_done;
        grant && !we;
    endsequence
    sequence s_write_req;
        req && we;
    endsequence
    a_grant_caused: assert property (grant |-> $past(mem_en) && $past(req))
        else $error("grant without a taken request");
    a_mem_then_grant: assert property (mem_en |=> grant)
        else $error("memory access not answered next cycle");
    a_req_held: assert property (req && !grant |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before grant");
    a_write_buffered: assert property (s_read_done ##1 s_write_req |-> wdata == $past(rdata))
        else $error("written byte differs from byte read");
    a_write_data_only: assert property (req && we |-> space == 2'h0)
        else $error("write outside data space");
    a_stall_tracks: assert property (cpu_stall == $past(dma_priority && req))
        else $error("processor stall wrong");
    a_take_allowed: assert property (mem_en |-> $past(dma_priority || cpu_bubble_next))
        else $error("engine used a busy processor cycle");
    a_mem_follows: assert property (mem_en |-> mem_addr == $past(addr) && mem_we == $past(we))
        else $error("memory port does not follow request");
    a_read_data: assert property (s_read_done |-> rdata == $past(mem_rdata))
        else $error("read data not passed through");
endmodule : bdte_checker

// *** testbench/byte_dma_transfer_engine_tb.sv ***
`timescale 1ns/100ps
module byte_dma_transfer_engine_tb;
    import bdte_pkg::*;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [PAW-1:0] paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [NTRIG-1:0] hw_trig;
    logic           dma_priority, cpu_bubble_next, cpu_stall, bub_toggle, mem_en, mem_we;
    logic [1:0]     mem_space;
    logic [AW-1:0]  mem_addr;
    logic [7:0]     mem_wdata, mem_rdata;
    logic [7:0]     mem [0:255];
    int             mismatches, cmp_count;
    ////////////////////////////////////////////////////////////////////////////////
    bdte_bus_if bdte_bus_if_inst ();
    bdte_engine bdte_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_trig(hw_trig), .bus(bdte_bus_if_inst.engine));
    bdte_arbiter bdte_arbiter_inst (.pclk(pclk), .presetn(presetn), .bus(bdte_bus_if_inst.arbiter),
        .dma_priority(dma_priority), .cpu_bubble_next(cpu_bubble_next), .cpu_stall(cpu_stall),
        .mem_en(mem_en), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    bdte_checker bdte_checker_inst (.pclk(pclk), .presetn(presetn), .req(bdte_bus_if_inst.req),
        .we(bdte_bus_if_inst.we), .space(bdte_bus_if_inst.space), .addr(bdte_bus_if_inst.addr),
        .wdata(bdte_bus_if_inst.wdata), .grant(bdte_bus_if_inst.grant), .rdata(bdte_bus_if_inst.rdata),
        .dma_priority(dma_priority), .cpu_bubble_next(cpu_bubble_next), .cpu_stall(cpu_stall),
        .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // flash and eeprom are patterns so every read space gives distinct bytes
    assign mem_rdata = (mem_space == 2'h1) ? (mem_addr[7:0] ^ 8'h5A) :
                       (mem_space == 2'h2) ? (mem_addr[7:0] ^ 8'hA5) : mem[mem_addr[7:0]];
    always @(posedge pclk) begin
        if (mem_en && mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
    // processor leaves every other cycle free while bub_toggle is set
    always @(posedge pclk) begin
        cpu_bubble_next <= bub_toggle ? ~cpu_bubble_next : 1'b0;
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [PAW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // read right after the edge: the value sampled at that edge
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            conclude();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input string name, input logic [PAW-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rdchk
    // configure one instance, start it by software or trigger, poll until go drops
    task automatic run(input logic [1:0] sel, input logic [15:0] ssa, input logic [15:0] dsa,
                       input logic [11:0] ssz, input logic [11:0] dsz, input logic [7:0] cb,
                       input logic sw, input logic [2:0] trg);
        int n;
        n = 0;
        apb(1'b1, OFF_SELECT, {30'h0, sel});
        apb(1'b1, OFF_CTLA, 32'h0);
        apb(1'b1, OFF_SSA, {16'h0, ssa});
        apb(1'b1, OFF_DSA, {16'h0, dsa});
        apb(1'b1, OFF_SSZ, {20'h0, ssz});
        apb(1'b1, OFF_DSZ, {20'h0, dsz});
        apb(1'b1, OFF_CTLB, {24'h0, cb});
        apb(1'b1, OFF_SIRQ, {29'h0, trg});
        apb(1'b1, OFF_CTLA, 32'h1);
        if (sw) begin
            apb(1'b1, OFF_CTLA, 32'h3);
        end else begin
            apb(1'b1, OFF_CTLA, 32'h5);
            @(posedge pclk);
            hw_trig[trg] <= 1'b1;
            @(posedge pclk);
            hw_trig <= '0;
        end
        rd = 32'h2;
        while (rd[CA_GO] !== 1'b0 && n < 200) begin
            apb(1'b0, OFF_CTLA, 32'h0);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            conclude();
        end
        chk("go cleared", 32'h0, {31'h0, rd[CA_GO]});
        chk("pending clear", 32'h0, {31'h0, rd[CA_PEND]});
    endtask : run
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] x;
        {psel, penable, pwrite, paddr, pwdata, hw_trig, bub_toggle} = '0;
        {mismatches, cmp_count} = '0;
        presetn = 1'b0;
        dma_priority = 1'b1;
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3C;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("src size reset", OFF_SSZ, 32'h1);
        rdchk("dst addr reset", OFF_DSA, 32'h0);
        apb(1'b0, 8'h38, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, OFF_SPTR, 32'hFFFF);
        rdchk("src ptr read-only", OFF_SPTR, 32'h0);
        // four bytes, both pointers incrementing, engine first; no pointer aims at arbiter state
        run(2'd0, 16'h0010, 16'h0080, 12'd4, 12'd4, 8'h05, 1'b1, 3'd0);
        for (int i = 0; i < 4; i++) chk("inc copy", {24'h0, (8'h10 + i[7:0]) ^ 8'h3C}, {24'h0, mem[8'h80 + i]});
        rdchk("src ptr reload", OFF_SPTR, 32'h10);
        rdchk("src cnt reload", OFF_SCNT, 32'h4);
        // flash then eeprom, source decrementing into a fixed place, processor first
        dma_priority <= 1'b0;
        bub_toggle   <= 1'b1;
        for (int s = 1; s < 3; s++) begin
            x = 8'h1E ^ ((s == 1) ? 8'h5A : 8'hA5);
            run(2'd1, 16'h0020, 16'h00C0, 12'd3, 12'd3, {2'b00, s[1:0], 2'b10, 2'b00}, 1'b1, 3'd0);
            chk("fixed dst last", {24'h0, x}, {24'h0, mem[8'hC0]});
            rdchk("holding buffer", OFF_BUF, {24'h0, x});
        end
        // unequal sizes end at the smaller count
        dma_priority <= 1'b1;
        bub_toggle   <= 1'b0;
        run(2'd2, 16'h0040, 16'h0090, 12'd2, 12'd4, 8'h05, 1'b1, 3'd0);
        rdchk("src cnt wrap", OFF_SCNT, 32'h2);
        rdchk("dst cnt left", OFF_DCNT, 32'h2);
        rdchk("dst ptr moved", OFF_DPTR, 32'h92);
        chk("second byte", {24'h0, 8'h41 ^ 8'h3C}, {24'h0, mem[8'h91]});
        apb(1'b1, OFF_SELECT, 32'h3);
        rdchk("other instance", OFF_SSZ, 32'h1);
        // hardware start on trigger line five
        run(2'd3, 16'h0050, 16'h00A0, 12'd1, 12'd1, 8'h00, 1'b0, 3'd5);
        chk("trig copy", {24'h0, 8'h50 ^ 8'h3C}, {24'h0, mem[8'hA0]});
        chk("start trig kept", 32'h1, {31'h0, rd[CA_STEN]});
        // same line again, stop on source wrap
        run(2'd3, 16'h0051, 16'h00A1, 12'd1, 12'd1, 8'h40, 1'b0, 3'd5);
        chk("stop copy", {24'h0, 8'h51 ^ 8'h3C}, {24'h0, mem[8'hA1]});
        chk("auto stop", 32'h0, {31'h0, rd[CA_STEN]});
        // abort on line six while the first read of instance 0 is on the bus
        apb(1'b1, OFF_SELECT, 32'h0);
        apb(1'b1, OFF_AIRQ, 32'h6);
        apb(1'b1, OFF_CTLA, 32'hB);
        @(posedge pclk);
        hw_trig[6] <= 1'b1;
        @(posedge pclk);
        hw_trig <= '0;
        repeat (4) @(posedge pclk);
        rdchk("abort stops go", OFF_CTLA, 32'h9);
        rdchk("abort no count", OFF_SCNT, 32'h4);
        // processor first with no free cycle: the read must wait
        dma_priority <= 1'b0;
        apb(1'b1, OFF_SELECT, 32'h2);
        apb(1'b1, OFF_CTLA, 32'h3);
        repeat (20) @(posedge pclk);
        rdchk("held by processor", OFF_CTLA, 32'h3);
        rdchk("nothing moved", OFF_SCNT, 32'h2);
        dma_priority <= 1'b1;
        repeat (20) @(posedge pclk);
        rdchk("released", OFF_CTLA, 32'h1);
        conclude();
    end
endmodule : byte_dma_transfer_engine_tb
